// ==== shared/ufc_pkg.sv ====
// Package for the UART FIFO and flow-control configuration block.
// Assumes a byte-wide register port driven by the bridge's host interface.
package ufc_pkg;
  localparam logic [2:0] OFS_FIFO_CTRL = 3'h2;
  localparam logic [2:0] OFS_LINE_CTRL = 3'h3;
  localparam logic [2:0] OFS_INT_ID    = 3'h2;
  localparam logic [7:0] FIFO_CTRL_RST = 8'h00;
  localparam logic [7:0] EFC_RST       = 8'h00;
  localparam logic [7:0] LINE_CTRL_RST = 8'h1D;
  localparam logic [7:0] EFC_KEY       = 8'hBF;
  // Field positions
  localparam int FC_EN      = 0;
  localparam int FC_RXRST   = 1;
  localparam int FC_TXRST   = 2;
  localparam int FC_TXT_LO  = 4;
  localparam int FC_RXT_LO  = 6;
  localparam int EF_CTS     = 7;
  localparam int EF_RTS     = 6;
  localparam int EF_SPEC    = 5;
  localparam int EF_ENH     = 4;
  localparam int LC_DIV     = 7;
  localparam int LC_BRK     = 6;
  localparam int SF_EFC_OFF = 2;
  localparam int EF_TXS_LO  = 2;
  localparam int EF_RXS_LO  = 0;
  // Flow-control select codes
  localparam logic [3:0] FLOW_ANY_1 = 4'hB;
  localparam logic [3:0] FLOW_ANY_2 = 4'h7;
  localparam logic [1:0] RXS_NONE   = 2'h0;
  localparam logic [1:0] RXS_SECOND = 2'h1;
  localparam logic [1:0] RXS_FIRST  = 2'h2;
  localparam logic [1:0] RXS_BOTH   = 2'h3;
  // Trigger levels, characters or spaces
  localparam logic [6:0] LVL_1  = 7'h01;
  localparam logic [6:0] LVL_8  = 7'h08;
  localparam logic [6:0] LVL_16 = 7'h10;
  localparam logic [6:0] LVL_32 = 7'h20;
  localparam logic [6:0] LVL_56 = 7'h38;
  localparam logic [6:0] LVL_60 = 7'h3C;
  localparam logic [6:0] DEPTH_FIFO   = 7'h40;
  localparam logic [6:0] DEPTH_SINGLE = 7'h01;
  // Pause/special character match states
  typedef enum logic [1:0] {
    UFC_NONE,
    UFC_PAUSE,
    UFC_SPECIAL
  } ufc_src_e;
endpackage : ufc_pkg

// ==== src/ufc_config.sv ====
// FIFO control, enhanced feature and line control bits for one UART channel.
// Assumes byte writes from the host port, and received bytes from the receiver.
//
// Contract
// - Receive trigger codes 00,01,10,11 select 8,16,56,60 characters.
// - Transmit trigger codes 00,01,10,11 select 8,16,32,56 free spaces.
// - Transmit FIFO reset bit clears the FIFO, spares shift register, self-clears.
// - Receive FIFO reset bit clears the FIFO, spares shift register, self-clears.
// - FIFO disabled: one character each way, other bits frozen, trigger one.
// - FIFO enabled: both FIFOs active, each holds 64 characters.
// - Transmit trigger field writable only while enhanced enable is one.
// - FIFO control at 02H writable only with divisor select zero; resets zero.
// - Enhanced feature at 02H reached with line control BF, special bit zero.
// - Enhanced bit 7 enables automatic CTS transmit flow control.
// - Enhanced bit 6 enables automatic RTS receive flow control.
// - Special detect: second pause char stored, special identification bit raised.
// - If flow compares second pause: byte dropped, pause and special raised.
// - Enhanced bit 4 gates writes to the transmit trigger field.
// - Select bits 3:2 choose transmitted pause/resume pairs.
// - Select bits 1:0 choose which pair the receiver compares.
// - Codes 1011 and 0111 let receiver accept either pair's character.
// - Codes 1111 and 0011 need both characters in sequence.
// - Line control bit 7 selects divisor latch; register resets to 1D.
// - Line control bit 6 forces transmit output low for break.
// - Special bit clears on identification read; pause-set clears on resume.
`timescale 1ns/100ps
module ufc_config
  import ufc_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_special_function,
  input  wire logic [7:0] i_resume_char_first,
  input  wire logic [7:0] i_resume_char_second,
  input  wire logic [7:0] i_pause_char_first,
  input  wire logic [7:0] i_pause_char_second,
  input  wire logic       i_rx_valid,
  input  wire logic [7:0] i_rx_data,
  input  wire logic       i_tx_serial,
  output logic            o_fifo_en,
  output logic            o_tx_fifo_clr,
  output logic            o_rx_fifo_clr,
  output logic [6:0]      o_rx_trigger,
  output logic [6:0]      o_tx_trigger,
  output logic [6:0]      o_fifo_depth,
  output logic            o_auto_cts,
  output logic            o_auto_rts,
  output logic            o_enhanced_en,
  output logic [1:0]      o_tx_flow_sel,
  output logic [1:0]      o_rx_flow_sel,
  output logic            o_divisor_sel,
  output logic            o_tx_pin,
  output logic            o_rx_store,
  output logic [7:0]      o_rx_store_data,
  output logic            o_pause_hit,
  output logic            o_resume_hit,
  output logic            o_special_int,
  output logic [7:0]      o_fifo_control,
  output logic [7:0]      o_enhanced_feature_control,
  output logic [7:0]      o_line_control
);

  logic [7:0] fifo_control_q;
  logic [7:0] efc_q;
  logic [7:0] line_control_q;
  logic [7:0] fifo_control_d;
  logic       special_q;
  logic       special_by_pause_q;
  logic       half_q;       // First character of a two-char sequence seen
  logic       half_pause_q; // That first character was a pause character

  // Address decode for the shared offset 02H and line control at 03H
  wire efc_key  = (line_control_q == EFC_KEY);
  wire efc_sel  = efc_key && !i_special_function[SF_EFC_OFF];
  wire wr_fc    = i_wr_en && (i_addr == OFS_FIFO_CTRL) && !efc_key
                  && !line_control_q[LC_DIV];
  wire wr_efc   = i_wr_en && (i_addr == OFS_FIFO_CTRL) && efc_sel;
  wire wr_lc    = i_wr_en && (i_addr == OFS_LINE_CTRL);
  wire rd_iid   = i_rd_en && (i_addr == OFS_INT_ID) && !line_control_q[LC_DIV]
                  && !efc_key;
  wire enh      = efc_q[EF_ENH];

  // Next FIFO control value: enable always, others only with FIFO enabled
  wire fen_new  = i_wdata[FC_EN];
  wire [1:0] tx_trig_new = enh ? i_wdata[FC_TXT_LO +: 2]
                               : fifo_control_q[FC_TXT_LO +: 2];
  always_comb begin
    fifo_control_d = fifo_control_q;
    fifo_control_d[FC_TXRST] = 1'b0;
    fifo_control_d[FC_RXRST] = 1'b0;
    if (wr_fc) begin
      fifo_control_d[FC_EN] = fen_new;
      if (fen_new) begin
        fifo_control_d[FC_RXT_LO +: 2] = i_wdata[FC_RXT_LO +: 2];
        fifo_control_d[FC_TXT_LO +: 2] = tx_trig_new;
        fifo_control_d[FC_TXRST]       = i_wdata[FC_TXRST];
        fifo_control_d[FC_RXRST]       = i_wdata[FC_RXRST];
      end
    end
  end

  // Trigger level lookup
  wire [1:0] rxc = fifo_control_q[FC_RXT_LO +: 2];
  wire [1:0] txc = fifo_control_q[FC_TXT_LO +: 2];
  wire [6:0] rx_lvl = (rxc == 2'h0) ? LVL_8 : (rxc == 2'h1) ? LVL_16 :
                      (rxc == 2'h2) ? LVL_56 : LVL_60;
  wire [6:0] tx_lvl = (txc == 2'h0) ? LVL_8 : (txc == 2'h1) ? LVL_16 :
                      (txc == 2'h2) ? LVL_32 : LVL_56;
  wire fen = fifo_control_q[FC_EN];

  // Receive character compare
  wire [1:0] txs = efc_q[EF_TXS_LO +: 2];
  wire [1:0] rxs = efc_q[EF_RXS_LO +: 2];
  wire p1 = (i_rx_data == i_pause_char_first);
  wire p2 = (i_rx_data == i_pause_char_second);
  wire r1 = (i_rx_data == i_resume_char_first);
  wire r2 = (i_rx_data == i_resume_char_second);
  wire any_pair = (efc_q[EF_RXS_LO +: 4] == FLOW_ANY_1) ||
                  (efc_q[EF_RXS_LO +: 4] == FLOW_ANY_2);
  wire both_seq = (rxs == RXS_BOTH) && !any_pair;
  wire p_single = any_pair ? (p1 || p2) : (rxs == RXS_FIRST) ? p1 :
                  (rxs == RXS_SECOND) ? p2 : 1'b0;
  wire r_single = any_pair ? (r1 || r2) : (rxs == RXS_FIRST) ? r1 :
                  (rxs == RXS_SECOND) ? r2 : 1'b0;
  // Two-character sequence: first then second of the same kind
  wire p_seq2   = both_seq && half_q && half_pause_q && p2;
  wire r_seq2   = both_seq && half_q && !half_pause_q && r2;
  wire p_first  = both_seq && p1;
  wire r_first  = both_seq && r1;
  wire flow_p2  = any_pair || (rxs == RXS_SECOND) || both_seq;      // Flow compares pause 2
  wire pause_ev = i_rx_valid && (p_single || p_seq2);
  wire resume_ev= i_rx_valid && (r_single || r_seq2);
  wire flow_chr = p_single || r_single || p_seq2 || r_seq2 || p_first || r_first;
  wire spec_ev  = i_rx_valid && efc_q[EF_SPEC] && p2;
  wire drop     = i_rx_valid && flow_chr && (rxs != RXS_NONE);
  wire spec_pause = spec_ev && flow_p2 && pause_ev;

  // Register update
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fifo_control_q <= FIFO_CTRL_RST;
      efc_q          <= EFC_RST;
      line_control_q <= LINE_CTRL_RST;
    end else begin
      fifo_control_q <= fifo_control_d;
      if (wr_efc) efc_q <= i_wdata;
      if (wr_lc) line_control_q <= i_wdata;
    end
  end

  // Sequence tracker for two-character compare
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      half_q       <= 1'b0;
      half_pause_q <= 1'b0;
    end else if (i_rx_valid) begin
      half_q       <= p_first || r_first;
      half_pause_q <= p_first;
    end
  end

  // Special identification flag; set wins over clear
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      special_q          <= 1'b0;
      special_by_pause_q <= 1'b0;
    end else if (spec_ev) begin
      special_q          <= 1'b1;
      special_by_pause_q <= spec_pause;
    end else if ((special_by_pause_q && resume_ev) ||
                 (!special_by_pause_q && rd_iid)) begin
      special_q          <= 1'b0;
      special_by_pause_q <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fifo_en      <= 1'b0;
      o_tx_fifo_clr  <= 1'b0;
      o_rx_fifo_clr  <= 1'b0;
      o_rx_trigger   <= LVL_1;
      o_tx_trigger   <= LVL_1;
      o_fifo_depth   <= DEPTH_SINGLE;
      o_auto_cts     <= 1'b0;
      o_auto_rts     <= 1'b0;
      o_enhanced_en  <= 1'b0;
      o_tx_flow_sel  <= 2'h0;
      o_rx_flow_sel  <= 2'h0;
      o_divisor_sel  <= 1'b0;
      o_tx_pin       <= 1'b1;
      o_rx_store     <= 1'b0;
      o_rx_store_data<= 8'h00;
      o_pause_hit    <= 1'b0;
      o_resume_hit   <= 1'b0;
      o_special_int  <= 1'b0;
      o_fifo_control <= FIFO_CTRL_RST;
      o_enhanced_feature_control <= EFC_RST;
      o_line_control <= LINE_CTRL_RST;
    end else begin
      o_fifo_en      <= fen;
      o_tx_fifo_clr  <= fifo_control_q[FC_TXRST];
      o_rx_fifo_clr  <= fifo_control_q[FC_RXRST];
      o_rx_trigger   <= fen ? rx_lvl : LVL_1;
      o_tx_trigger   <= fen ? tx_lvl : LVL_1;
      o_fifo_depth   <= fen ? DEPTH_FIFO : DEPTH_SINGLE;
      o_auto_cts     <= efc_q[EF_CTS];
      o_auto_rts     <= efc_q[EF_RTS];
      o_enhanced_en  <= enh;
      o_tx_flow_sel  <= txs;
      o_rx_flow_sel  <= rxs;
      o_divisor_sel  <= line_control_q[LC_DIV];
      o_tx_pin       <= i_tx_serial && !line_control_q[LC_BRK];
      o_rx_store     <= i_rx_valid && !drop;
      o_rx_store_data<= i_rx_data;
      o_pause_hit    <= pause_ev;
      o_resume_hit   <= resume_ev;
      o_special_int  <= special_q;
      o_fifo_control <= fifo_control_q;
      o_enhanced_feature_control <= efc_q;
      o_line_control <= line_control_q;
    end
  end

  // Checks
  property p_txrst_selfclear;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      fifo_control_q[FC_TXRST] && !wr_fc |=> !fifo_control_q[FC_TXRST];
  endproperty
  a_txrst_selfclear: assert property (p_txrst_selfclear) else $error("tx reset stuck");
  // Clear output high for exactly one cycle
  sequence s_rx_clr_pulse;
    o_rx_fifo_clr ##1 !o_rx_fifo_clr;
  endsequence
  property p_rxrst_pulse;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      fifo_control_q[FC_RXRST] && !wr_fc |=> s_rx_clr_pulse;
  endproperty
  a_rxrst_pulse: assert property (p_rxrst_pulse) else $error("rx clear not one pulse");
  property p_single_trig;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      !fen |=> (o_rx_trigger == LVL_1) && (o_fifo_depth == DEPTH_SINGLE);
  endproperty
  a_single_trig: assert property (p_single_trig) else $error("non-FIFO trigger wrong");
  property p_tx_trig_lock;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      !enh |=> $stable(fifo_control_q[FC_TXT_LO +: 2]);
  endproperty
  a_tx_trig_lock: assert property (p_tx_trig_lock) else $error("tx trigger changed");
  property p_fc_lock;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      line_control_q[LC_DIV] |=> $stable(fifo_control_q[FC_RXT_LO +: 2]);
  endproperty
  a_fc_lock: assert property (p_fc_lock) else $error("fifo control written");
  property p_break;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      line_control_q[LC_BRK] |=> !o_tx_pin;
  endproperty
  a_break: assert property (p_break) else $error("break not driven");
  property p_rx56;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (fen && rxc == 2'h2) |=> (o_rx_trigger == LVL_56);
  endproperty
  a_rx56: assert property (p_rx56) else $error("rx trigger 56 wrong");
  property p_tx32;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (fen && txc == 2'h2) |=> (o_tx_trigger == LVL_32);
  endproperty
  a_tx32: assert property (p_tx32) else $error("tx trigger 32 wrong");
  // Flag first, then its registered output
  sequence s_special_raise;
    special_q ##1 o_special_int;
  endsequence
  property p_spec_set;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      spec_ev |=> s_special_raise;
  endproperty
  a_spec_set: assert property (p_spec_set) else $error("special flag missed");
  // Flow character kept out of the FIFO, pause reported
  sequence s_pause_drop;
    o_pause_hit && !o_rx_store;
  endsequence
  property p_pause_special;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      spec_ev && flow_p2 && pause_ev |=> s_pause_drop ##1 o_special_int;
  endproperty
  a_pause_special: assert property (p_pause_special) else $error("pause special wrong");
  property p_resume_clear;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      special_by_pause_q && resume_ev && !spec_ev |=> !special_q;
  endproperty
  a_resume_clear: assert property (p_resume_clear) else $error("resume clear missed");
  property p_efc_lock;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      !(i_wr_en && (i_addr == OFS_FIFO_CTRL) && efc_key && !i_special_function[SF_EFC_OFF])
      |=> $stable(efc_q);
  endproperty
  a_efc_lock: assert property (p_efc_lock) else $error("enhanced reg written");
  property p_div_sel;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      line_control_q[LC_DIV] |=> o_divisor_sel;
  endproperty
  a_div_sel: assert property (p_div_sel) else $error("divisor select wrong");
  property p_fifo_depth;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      fen |=> (o_fifo_depth == DEPTH_FIFO);
  endproperty
  a_fifo_depth: assert property (p_fifo_depth) else $error("fifo depth wrong");
  property p_auto_cts;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      efc_q[EF_CTS] |=> o_auto_cts;
  endproperty
  a_auto_cts: assert property (p_auto_cts) else $error("auto cts not shown");
endmodule : ufc_config

// ==== tb/uart_fifo_and_flow_control_config_bench.sv ====
// Self-checking bench for the FIFO and flow-control configuration block.
// Assumes ufc_pkg and ufc_config compiled first, and the remote device model.
`timescale 1ns/100ps
module uart_fifo_and_flow_control_config_bench;
  import ufc_pkg::*;
  logic       i_sys_clk = 1'b0;
  logic       i_resetn, i_wr_en, i_rd_en, i_tx_serial, i_rx_valid;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, i_special_function, i_rx_data;
  logic [7:0] i_resume_char_first, i_resume_char_second, i_pause_char_first, i_pause_char_second;
  logic       o_fifo_en, o_tx_fifo_clr, o_rx_fifo_clr, o_auto_cts, o_auto_rts, o_enhanced_en;
  logic       o_divisor_sel, o_tx_pin, o_rx_store, o_pause_hit, o_resume_hit, o_special_int;
  logic [6:0] o_rx_trigger, o_tx_trigger, o_fifo_depth;
  logic [1:0] o_tx_flow_sel, o_rx_flow_sel;
  logic [7:0] o_rx_store_data, o_fifo_control, o_enhanced_feature_control, o_line_control;
  int         n_mismatch = 0;
  int         compares = 0;
  int         cyc = 0;
  int         fc, efc, lc;
  logic [2:0] a;
  logic [7:0] d;

  ufc_config dut_u (.i_sys_clk, .i_resetn, .i_wr_en, .i_rd_en, .i_addr, .i_wdata,
    .i_special_function, .i_resume_char_first, .i_resume_char_second, .i_pause_char_first,
    .i_pause_char_second, .i_rx_valid, .i_rx_data, .i_tx_serial, .o_fifo_en, .o_tx_fifo_clr,
    .o_rx_fifo_clr, .o_rx_trigger, .o_tx_trigger, .o_fifo_depth, .o_auto_cts, .o_auto_rts,
    .o_enhanced_en, .o_tx_flow_sel, .o_rx_flow_sel, .o_divisor_sel, .o_tx_pin, .o_rx_store,
    .o_rx_store_data, .o_pause_hit, .o_resume_hit, .o_special_int, .o_fifo_control,
    .o_enhanced_feature_control, .o_line_control);
  ufc_remote rem_u (.i_sys_clk(i_sys_clk), .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data));

  // Clock and hang guard
  always #10 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Register write, then the reference model takes the same write
  task automatic wr(input logic [2:0] wa, input logic [7:0] wd);
    @(posedge i_sys_clk);
    i_wr_en <= 1'b1;
    i_addr  <= wa;
    i_wdata <= wd;
    @(posedge i_sys_clk);
    i_wr_en <= 1'b0;
    if (wa == 3'h3) lc = wd;
    else if (wa == 3'h2 && lc == 8'hBF) begin
      if (!i_special_function[2]) efc = wd;
    end else if (wa == 3'h2 && !lc[7]) begin
      if (wd[0]) fc = {wd[7:6], efc[4] ? wd[5:4] : 2'(fc[5:4]), 4'h1};
      else fc[0] = 0;
    end
  endtask : wr

  task automatic id_read();
    @(posedge i_sys_clk);
    i_rd_en <= 1'b1;
    i_addr  <= 3'h2;
    @(posedge i_sys_clk);
    i_rd_en <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
  endtask : id_read

  // Compare every configuration output except the two FIFO clear pulses with the model
  task automatic all_chk();
    int rt, tt;
    rt = fc[0] ? (fc[7:6] == 0 ? 8 : fc[7:6] == 1 ? 16 : fc[7:6] == 2 ? 56 : 60) : 1;
    tt = fc[0] ? (fc[5:4] == 0 ? 8 : fc[5:4] == 1 ? 16 : fc[5:4] == 2 ? 32 : 56) : 1;
    chk("fifo_en", 8'(fc[0]), {7'h00, o_fifo_en});
    chk("rx_trigger", 8'(rt), {1'b0, o_rx_trigger});
    chk("tx_trigger", 8'(tt), {1'b0, o_tx_trigger});
    chk("depth", fc[0] ? 8'h40 : 8'h01, {1'b0, o_fifo_depth});
    chk("fifo_control", 8'(fc), o_fifo_control);
    chk("enhanced", 8'(efc), o_enhanced_feature_control);
    chk("line_control", 8'(lc), o_line_control);
    chk("efc_bits", 8'({efc[7:6], efc[4], efc[3:0]}), {1'b0, o_auto_cts, o_auto_rts,
        o_enhanced_en, o_tx_flow_sel, o_rx_flow_sel});
    chk("lc_bits", 8'({lc[7], lc[6] ? 1'b0 : i_tx_serial}),
        {6'h00, o_divisor_sel, o_tx_pin});
  endtask : all_chk

  // Enhanced register load through the key value, then back to normal decode
  task automatic set_efc(input logic [7:0] v);
    wr(3'h3, 8'hBF);
    wr(3'h2, v);
    wr(3'h3, 8'h03);
  endtask : set_efc

  // Received byte; e = {ignore store, store, pause hit, resume hit}
  task automatic rx(input logic [7:0] b, input logic [3:0] e);
    rem_u.send_byte(b, 1);
    #1;
    chk("rx_hits", {5'h00, e[2] & ~e[3], e[1:0]},
        {5'h00, o_rx_store & ~e[3], o_pause_hit, o_resume_hit});
    if (e[2]) chk("rx_data", b, o_rx_store_data);
  endtask : rx

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    {i_resetn, i_wr_en, i_rd_en, i_addr, i_wdata} = '0;
    i_tx_serial = 1'b1;
    i_special_function = 8'h00;
    {i_resume_char_first, i_resume_char_second} = {8'h11, 8'h12};
    {i_pause_char_first, i_pause_char_second} = {8'h13, 8'h14};
    {fc, efc, lc} = {32'h0, 32'h0, 32'h1D};
    void'($urandom(32'hA13C9606));
    repeat (12) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    @(posedge i_sys_clk);
    #1 all_chk();
    $display("test reset values done");
    for (int k = 0; k < 80; k++) begin
      a = ($urandom % 2) ? 3'h2 : 3'h3;
      d = 8'($urandom) & 8'hF7;
      if (a == 3'h3 && $urandom % 3 == 0) d = 8'hBF;
      @(posedge i_sys_clk);
      i_special_function <= 8'($urandom);
      i_tx_serial <= 1'($urandom);
      wr(a, d);
      repeat (3) @(posedge i_sys_clk);
      #1 all_chk();
    end
    $display("test random writes done");
    @(posedge i_sys_clk);
    i_special_function <= 8'h00;
    wr(3'h3, 8'h03);
    wr(3'h2, 8'h07);
    @(posedge i_sys_clk);
    #1 chk("clr_pulses", 8'h03, {6'h00, o_tx_fifo_clr, o_rx_fifo_clr});
    @(posedge i_sys_clk);
    #1 chk("clr_end", 8'h00, {6'h00, o_tx_fifo_clr, o_rx_fifo_clr});
    wr(3'h2, 8'h06);
    @(posedge i_sys_clk);
    #1 chk("clr_off", 8'h00, {6'h00, o_tx_fifo_clr, o_rx_fifo_clr});
    repeat (2) @(posedge i_sys_clk);
    #1 all_chk();
    $display("test fifo reset bits done");
    set_efc(8'h20);
    rx(8'h55, 4'b0100);
    rx(8'h14, 4'b0100);
    @(posedge i_sys_clk);
    #1 chk("special", 8'h01, {7'h00, o_special_int});
    id_read();
    #1 chk("special_rd", 8'h00, {7'h00, o_special_int});
    set_efc(8'h21);
    rx(8'h14, 4'b0010);
    @(posedge i_sys_clk);
    #1 chk("special_p", 8'h01, {7'h00, o_special_int});
    id_read();
    #1 chk("special_hold", 8'h01, {7'h00, o_special_int});
    rx(8'h12, 4'b0001);
    repeat (2) @(posedge i_sys_clk);
    #1 chk("special_res", 8'h00, {7'h00, o_special_int});
    set_efc(8'h0B);
    rx(8'h12, 4'b0001);
    rx(8'h14, 4'b0010);
    set_efc(8'h0F);
    rx(8'h13, 4'b1000);
    rx(8'h14, 4'b1010);
    set_efc(8'h02);
    rx(8'h13, 4'b0010);
    rx(8'h14, 4'b0100);
    rx(8'h11, 4'b0001);
    set_efc(8'h27);
    rx(8'h14, 4'b0010);
    rx(8'h11, 4'b0001);
    #1 chk("special_any", 8'h01, {7'h00, o_special_int});
    @(posedge i_sys_clk);
    #1 chk("special_any_res", 8'h00, {7'h00, o_special_int});
    $display("test receive matching done");
    end_sim();
  end
endmodule : uart_fifo_and_flow_control_config_bench

// ==== tb/ufc_remote.sv ====
// Remote serial device model: hands received bytes to the block.
// Assumes the bench clock; the bench calls send_byte and checks the result.
`timescale 1ns/100ps
module ufc_remote (
  input  wire logic       i_sys_clk,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data
);
  // Idle lines at time zero
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'hA5;
  end

  // One byte for one cycle after an optional delay; data lines then turn over
  task automatic send_byte(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b1;
    o_rx_data  <= b;
    @(posedge i_sys_clk);
    o_rx_valid <= 1'b0;
    o_rx_data  <= ~b;
  endtask : send_byte
endmodule : ufc_remote
